// *** logic/uii_pkg.sv ***
// Constants and types shared by the interrupt identification block.
// Assumes an 8-bit host port with 3-bit register offsets.
package uii_pkg;

  localparam logic [2:0] OFS_RX_TX      = 3'h0;
  localparam logic [2:0] OFS_IDENT_FCTL = 3'h2;
  localparam logic [2:0] OFS_LINE_STAT  = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;

  // Enable bit positions in interrupt_enable_reg
  localparam int EN_RX_DATA = 0;
  localparam int EN_TX_EMPTY = 1;
  localparam int EN_LINE     = 2;
  localparam int EN_MODEM    = 3;

  // fifo_control bit positions
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;
  localparam int FC_TRIG_LO  = 6;
  localparam int FC_TRIG_HI  = 7;

  // Identification source codes, bits 2:1
  localparam logic [1:0] SRC_LINE   = 2'h3;
  localparam logic [1:0] SRC_RXDATA = 2'h2;
  localparam logic [1:0] SRC_TXEMPTY = 2'h1;
  localparam logic [1:0] SRC_MODEM  = 2'h0;

  localparam logic [1:0] MODE_FIFO    = 2'h3;
  localparam logic [1:0] MODE_NO_FIFO = 2'h0;
  localparam logic [7:0] IDENT_RESET  = 8'h01;
  localparam logic [1:0] TRIG_RESET   = 2'h0;

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_BYTES_0 = 5'h01;
  localparam logic [4:0] TRIG_BYTES_1 = 5'h04;
  localparam logic [4:0] TRIG_BYTES_2 = 5'h08;
  localparam logic [4:0] TRIG_BYTES_3 = 5'h0e;

  // Character times of silence before a timeout
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

  typedef struct packed {
    logic [7:0] ident;
    logic       rd_prev;
    logic       rd_ident;
    logic       tx_reported;
    logic       line_pend;
    logic       tx_pend;
    logic       modem_pend;
    logic       fifo_en;
    logic [1:0] trig;
    logic       tx_flush;
    logic       rx_flush;
    logic       irq;
  } uii_state_s;

  typedef struct packed {
    logic [2:0] chars;
    logic       flag;
  } uii_timer_s;

endpackage

// *** logic/uii_timeout_if.sv ***
// Link between the identification logic and its character timer.
// Both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface uii_timeout_if;
  logic enable;
  logic char_tick;
  logic rx_activity;
  logic rx_nonempty;
  logic timeout;

  modport ctrl  (output enable, output char_tick, output rx_activity,
                 output rx_nonempty, input timeout);
  modport timer (input enable, input char_tick, input rx_activity,
                 input rx_nonempty, output timeout);
endinterface
`default_nettype wire

// *** logic/uii_char_timeout.sv ***
// Receive character timeout counter.
// Expects one char_tick pulse per character time from the baud logic.
`timescale 1ns/1ps
`default_nettype none
module uii_char_timeout
  import uii_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset_n,
  uii_timeout_if.timer tif
);

  uii_timer_s st_ff;
  uii_timer_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // Any push or pop restarts the silence window
    if (!tif.enable || !tif.rx_nonempty || tif.rx_activity) begin
      nxt_st.chars = '0;
      nxt_st.flag  = 1'b0;
    end else begin
      if (tif.char_tick && st_ff.chars != TIMEOUT_CHARS) begin
        nxt_st.chars = st_ff.chars + 3'h1;
      end
      nxt_st.flag = (nxt_st.chars == TIMEOUT_CHARS);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tif.timeout = st_ff.flag;

endmodule
`default_nettype wire

// *** logic/uii_top.sv ***
// Interrupt identification and FIFO control for one serial port.
// Assumes host strobes synchronous to clock; rd held for the access.
`timescale 1ns/1ps
`default_nettype none
module uii_top
  import uii_pkg::*;
#(
  parameter int COUNT_W = 5
)
(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic [2:0]         addr,
  input  wire logic               rd,
  input  wire logic               wr,
  input  wire logic [7:0]         wdata,
  input  wire logic               dlab,
  input  wire logic [3:0]         interrupt_enable_reg,
  input  wire logic               line_event,
  input  wire logic               tx_empty_event,
  input  wire logic               modem_event,
  input  wire logic [COUNT_W-1:0] rx_count,
  input  wire logic               rx_push,
  input  wire logic               char_tick,
  output logic [7:0]              ident_rdata,
  output logic                    irq,
  output logic                    fifos_enable_bit,
  output logic [1:0]              rx_trigger_level,
  output logic                    tx_fifo_flush,
  output logic                    rx_fifo_flush
);

  ////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [COUNT_W-1:0] trig_bytes(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_bytes = COUNT_W'(TRIG_BYTES_0);
      2'h1:    trig_bytes = COUNT_W'(TRIG_BYTES_1);
      2'h2:    trig_bytes = COUNT_W'(TRIG_BYTES_2);
      default: trig_bytes = COUNT_W'(TRIG_BYTES_3);
    endcase
  endfunction

  // Priority encode into the identification byte
  function automatic logic [7:0] ident_byte(input logic fifo,
                                            input logic line,
                                            input logic rxd,
                                            input logic tmo,
                                            input logic txe,
                                            input logic mdm);
    logic [7:0] b;
    b = '0;
    b[7:6] = fifo ? MODE_FIFO : MODE_NO_FIFO;
    b[0] = 1'b1;
    if (line) begin
      b[2:1] = SRC_LINE;
      b[0]   = 1'b0;
    end else if (rxd || tmo) begin
      b[2:1] = SRC_RXDATA;
      b[3]   = tmo & fifo;
      b[0]   = 1'b0;
    end else if (txe) begin
      b[2:1] = SRC_TXEMPTY;
      b[0]   = 1'b0;
    end else if (mdm) begin
      b[2:1] = SRC_MODEM;
      b[0]   = 1'b0;
    end
    return b;
  endfunction

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Character timer

  uii_timeout_if tif ();

  uii_state_s st_ff;
  uii_state_s nxt_st;

  logic rd_start;
  logic rd_end;
  logic rx_read;
  logic tx_write;
  logic fc_write;
  logic line_read;
  logic modem_read;
  logic rxd_live;
  logic tmo_live;
  logic [7:0] live;

  assign rd_start   = rd && !st_ff.rd_prev;
  assign rd_end     = !rd && st_ff.rd_prev;
  assign rx_read    = rd_start && !dlab && hit(addr, OFS_RX_TX);
  assign tx_write   = wr && !dlab && hit(addr, OFS_RX_TX);
  assign fc_write   = wr && hit(addr, OFS_IDENT_FCTL);
  assign line_read  = rd_start && hit(addr, OFS_LINE_STAT);
  assign modem_read = rd_start && hit(addr, OFS_MODEM_STAT);

  assign tif.enable      = st_ff.fifo_en;
  assign tif.char_tick   = char_tick;
  assign tif.rx_activity = rx_push || rx_read;
  assign tif.rx_nonempty = rx_count != '0;

  uii_char_timeout u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .tif     (tif)
  );

  ////////////////////////////////////////////////////////////////////
  // Live identification, gated by the enables

  always_comb begin
    if (st_ff.fifo_en) begin
      rxd_live = rx_count >= trig_bytes(st_ff.trig);
    end else begin
      rxd_live = rx_count != '0;
    end
    rxd_live = rxd_live && interrupt_enable_reg[EN_RX_DATA];
    tmo_live = tif.timeout && st_ff.fifo_en && interrupt_enable_reg[EN_RX_DATA];
    live = ident_byte(st_ff.fifo_en,
                      st_ff.line_pend && interrupt_enable_reg[EN_LINE],
                      rxd_live,
                      tmo_live,
                      st_ff.tx_pend && interrupt_enable_reg[EN_TX_EMPTY],
                      st_ff.modem_pend && interrupt_enable_reg[EN_MODEM]);
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rd_prev  = rd;
    nxt_st.tx_flush = 1'b0;
    nxt_st.rx_flush = 1'b0;

    // Report frozen for the whole identification read
    if (rd_start && hit(addr, OFS_IDENT_FCTL)) begin
      nxt_st.ident       = live;
      nxt_st.rd_ident    = 1'b1;
      nxt_st.tx_reported = (live[0] == 1'b0) && (live[2:1] == SRC_TXEMPTY);
    end else if (st_ff.rd_ident && rd) begin
      nxt_st.ident = st_ff.ident;
    end else begin
      nxt_st.ident    = live;
      nxt_st.rd_ident = 1'b0;
    end

    // Clears first, so a same-cycle event wins
    if (line_read) begin
      nxt_st.line_pend = 1'b0;
    end
    if (modem_read) begin
      nxt_st.modem_pend = 1'b0;
    end
    if (tx_write || (rd_end && st_ff.rd_ident && st_ff.tx_reported)) begin
      nxt_st.tx_pend     = 1'b0;
      nxt_st.tx_reported = 1'b0;
    end
    // Events keep landing during a frozen read
    if (line_event) begin
      nxt_st.line_pend = 1'b1;
    end
    if (modem_event) begin
      nxt_st.modem_pend = 1'b1;
    end
    if (tx_empty_event) begin
      nxt_st.tx_pend = 1'b1;
    end

    // Other bits only land with the enable bit set
    if (fc_write) begin
      if (wdata[FC_ENABLE]) begin
        nxt_st.fifo_en  = 1'b1;
        nxt_st.trig     = wdata[FC_TRIG_HI:FC_TRIG_LO];
        nxt_st.tx_flush = wdata[FC_TX_FLUSH] || !st_ff.fifo_en;
        nxt_st.rx_flush = wdata[FC_RX_FLUSH] || !st_ff.fifo_en;
      end else begin
        nxt_st.fifo_en  = 1'b0;
        nxt_st.tx_flush = 1'b1;
        nxt_st.rx_flush = 1'b1;
      end
    end

    nxt_st.irq = !live[0];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff       <= '0;
      st_ff.ident <= IDENT_RESET;
      st_ff.trig  <= TRIG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign ident_rdata      = st_ff.ident;
  assign irq              = st_ff.irq;
  assign fifos_enable_bit = st_ff.fifo_en;
  assign rx_trigger_level = st_ff.trig;
  assign tx_fifo_flush    = st_ff.tx_flush;
  assign rx_fifo_flush    = st_ff.rx_flush;

endmodule
`default_nettype wire

// *** testbench/uii_checker.sv ***
// Port checker for the identification block.
// Bound into uii_top below; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module uii_checker
  import uii_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [2:0] addr,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] interrupt_enable_reg,
  input wire logic [7:0] ident_rdata,
  input wire logic       irq,
  input wire logic       fifos_enable_bit,
  input wire logic [1:0] rx_trigger_level,
  input wire logic       tx_fifo_flush,
  input wire logic       rx_fifo_flush
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  sequence s_fctl_on;
    wr && addr == OFS_IDENT_FCTL && wdata[FC_ENABLE];
  endsequence
  sequence s_fctl_off;
    wr && addr == OFS_IDENT_FCTL && !wdata[FC_ENABLE];
  endsequence
  // Three quiet cycles let a frozen copy and irq catch up
  sequence s_all_masked;
    (!rd && interrupt_enable_reg == 4'h0)[*3];
  endsequence
  ////////////////////////////////////////////////////////////
  AST_MODE_FIELD: assert property (
    ident_rdata[7:6] == MODE_FIFO || ident_rdata[7:6] == MODE_NO_FIFO) else $error("bad mode");
  AST_NO_TMO_OFF: assert property (!fifos_enable_bit && $past(!fifos_enable_bit) &&
    !rd && $past(!rd) |-> !ident_rdata[3]) else $error("timeout bit outside fifo mode");
  AST_TMO_CODE: assert property (ident_rdata[3] |-> ident_rdata[2:0] == 3'h4)
    else $error("timeout code");
  AST_IDLE_CODE: assert property (ident_rdata[0] |-> ident_rdata[3:1] == 3'h0)
    else $error("idle code");
  // Start edge captures a fresh value, so compare only from the second held cycle
  AST_FREEZE: assert property ($past(rd) && $past(rd, 2) &&
    $past(addr) == OFS_IDENT_FCTL && $past(addr, 2) == OFS_IDENT_FCTL |->
    $stable(ident_rdata)) else $error("ident moved in read");
  AST_FCTL_OFF: assert property (s_fctl_off |=>
    rx_fifo_flush && tx_fifo_flush && !fifos_enable_bit) else $error("disable write");
  AST_FCTL_ON: assert property (s_fctl_on |=> fifos_enable_bit &&
    rx_trigger_level == $past(wdata[7:6]) &&
    rx_fifo_flush == ($past(wdata[FC_RX_FLUSH]) || !$past(fifos_enable_bit)) &&
    tx_fifo_flush == ($past(wdata[FC_TX_FLUSH]) || !$past(fifos_enable_bit)))
    else $error("enable write");
  AST_FLUSH_CAUSE: assert property ((tx_fifo_flush || rx_fifo_flush) |->
    $past(wr) && $past(addr) == OFS_IDENT_FCTL) else $error("flush without write");
  // Outside a held read, irq and the report come from the same live value
  AST_IRQ_REPORT: assert property (!$past(rd) |-> irq == !ident_rdata[0])
    else $error("irq disagrees with report");
  AST_MASKED: assert property (s_all_masked |-> ident_rdata[0] && !irq)
    else $error("masked source seen");
endmodule
bind uii_top uii_checker chk (.clock(clock), .reset_n(reset_n), .addr(addr), .rd(rd),
  .wr(wr), .wdata(wdata), .interrupt_enable_reg(interrupt_enable_reg),
  .ident_rdata(ident_rdata), .irq(irq), .fifos_enable_bit(fifos_enable_bit),
  .rx_trigger_level(rx_trigger_level), .tx_fifo_flush(tx_fifo_flush),
  .rx_fifo_flush(rx_fifo_flush));
`default_nettype wire

// *** testbench/uii_host_model.sv ***
// Host processor model for the register port.
// Changes its outputs on falling clock edges only.
`timescale 1ns/1ps
`default_nettype none
module uii_host_model
  import uii_pkg::*;
(
  input  wire logic       clock,
  output var  logic [2:0] addr,
  output var  logic       rd,
  output var  logic       wr,
  output var  logic [7:0] wdata,
  output var  logic       dlab
);
  initial {addr, rd, wr, wdata, dlab} = 14'h0000;
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clock);
    {wdata, wr} = {~d, 1'b0};
  endtask
  // Enable forced if any other bit is set, else trigger and flush bits are lost
  task automatic write_fctl(input logic [7:0] d);
    write_reg(OFS_IDENT_FCTL, {d[7:1], d[0] | (|d[7:1])});
  endtask
  task automatic read_start(input logic [2:0] a, input logic dl);
    @(negedge clock);
    {addr, dlab, rd} = {a, dl, 1'b1};
  endtask
  task automatic read_end();
    @(negedge clock);
    {addr, rd} = {~addr, 1'b0};
  endtask
endmodule
`default_nettype wire

// *** testbench/uii_top_tb.sv ***
// Random and directed bench for the identification block.
// Host model owns the register port; this module drives events.
`timescale 1ns/1ps
`default_nettype none
module uii_top_tb import uii_pkg::*;;
  logic       clock, reset_n, rd, wr, dlab, irq, fen, txf, rxf, ln, tx, md, tm, fifo;
  logic [2:0] addr;
  logic [7:0] wdata, ident_rdata, e;
  logic [3:0] ien;
  logic [4:0] ev, cnt;
  logic [1:0] trg, trig;
  int         seed = 14216;
  int         r, err_total, comparisons;
  logic [4:0] lvl [4] = '{TRIG_BYTES_0, TRIG_BYTES_1, TRIG_BYTES_2, TRIG_BYTES_3};
  uii_host_model host (.clock(clock), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .dlab(dlab));
  uii_top dut (.clock(clock), .reset_n(reset_n), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .dlab(dlab), .interrupt_enable_reg(ien), .line_event(ev[0]),
    .tx_empty_event(ev[1]), .modem_event(ev[2]), .rx_count(cnt), .rx_push(ev[3]),
    .char_tick(ev[4]), .ident_rdata(ident_rdata), .irq(irq), .fifos_enable_bit(fen),
    .rx_trigger_level(trg), .tx_fifo_flush(txf), .rx_fifo_flush(rxf));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_ident();
    logic [1:0] m;
    m = fifo ? MODE_FIFO : MODE_NO_FIFO;
    if (ln && ien[EN_LINE]) return {m, 3'h0, SRC_LINE, 1'b0};
    if (tm && fifo && ien[EN_RX_DATA]) return {m, 3'h1, SRC_RXDATA, 1'b0};
    if (ien[EN_RX_DATA] && (fifo ? cnt >= lvl[trig] : cnt != 5'h00))
      return {m, 3'h0, SRC_RXDATA, 1'b0};
    if (tx && ien[EN_TX_EMPTY]) return {m, 3'h0, SRC_TXEMPTY, 1'b0};
    if (md && ien[EN_MODEM]) return {m, 3'h0, SRC_MODEM, 1'b0};
    return {m, 6'h01};
  endfunction
  task automatic chk_byte(input string n, input logic [7:0] x, input logic [7:0] g);
    comparisons++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic look();
    repeat (4) @(negedge clock);
    e = exp_ident();
    chk_byte("ident_rdata", e, ident_rdata);
    chk_byte("irq", {7'h00, ~e[0]}, {7'h00, irq});
  endtask
  task automatic pulse(input logic [4:0] p);
    @(negedge clock);
    ev = p;
    @(negedge clock);
    ev = 5'h00;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic dl);
    host.read_start(a, dl);
    host.read_end();
  endtask
  task automatic fctl(input logic [7:0] d);
    logic [1:0] fl;
    // Mode change or disable flushes both, else only the bits asked for
    fl = (d[FC_ENABLE] && fifo) ? {d[FC_TX_FLUSH], d[FC_RX_FLUSH]} : 2'h3;
    host.write_fctl(d);
    chk_byte("flush pulses", {6'h00, fl}, {6'h00, txf, rxf});
    if (d[FC_ENABLE]) trig = d[7:6];
    fifo = d[FC_ENABLE];
    repeat (2) @(negedge clock);
    chk_byte("fifo mode", {5'h00, fifo, trig}, {3'h0, txf, rxf, fen, trg});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n, ien, ev, cnt, ln, tx, md, tm, fifo, trig} = 22'h0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    chk_byte("fifo outputs", 8'h00, {3'h0, fen, trg, txf, rxf});
    look();
    // Each pass clears every source so the next pass proves the clears
    repeat (40) begin
      r = $random(seed);
      if (r[14:13] == 2'h0) fctl(r[16] ? {r[18:17], 3'h0, r[20:19], 1'b1} : 8'h00);
      ien = r[9:6];
      cnt = fifo ? 5'(r[4:0] % 17) : {4'h0, r[5]};
      pulse({2'h0, r[12:10]});
      {md, tx, ln} = r[12:10];
      look();
      rd_reg(OFS_LINE_STAT, 1'b0);
      rd_reg(OFS_MODEM_STAT, 1'b0);
      host.write_reg(OFS_RX_TX, r[31:24]);
      {ln, tx, md, cnt} = 8'h00;
    end
    ien = 4'h1;
    for (int t = 0; t < 4; t++) begin
      fctl({t[1:0], 3'h0, t[0], t[1], 1'b1});
      cnt = lvl[t] - 5'h01;
      look();
      cnt = lvl[t];
      look();
    end
    cnt = 5'h00;
    ien = 4'hf;
    pulse(5'h02);
    tx = 1'b1;
    look();
    host.read_start(OFS_IDENT_FCTL, 1'b0);
    pulse(5'h01);
    ln = 1'b1;
    repeat (2) @(negedge clock);
    chk_byte("frozen ident", e, ident_rdata);
    host.read_end();
    tx = 1'b0;
    look();
    rd_reg(OFS_LINE_STAT, 1'b0);
    ln = 1'b0;
    look();
    fctl(8'h41);
    ien = 4'h1;
    cnt = 5'h02;
    pulse(5'h08);
    repeat (3) pulse(5'h10);
    look();
    pulse(5'h10);
    tm = 1'b1;
    look();
    rd_reg(OFS_RX_TX, 1'b1);
    look();
    rd_reg(OFS_RX_TX, 1'b0);
    tm = 1'b0;
    look();
    fctl(8'h00);
    cnt = 5'h01;
    repeat (4) pulse(5'h10);
    look();
    give_verdict();
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
